// >>> rtl/srb_top.sv
// SPI status readback: frame commit, readback select and status word
`timescale 1ns/1ns
// Overview of operation
// - Select falling loads status word; shifted out top bit first.
// - First sixteen bits answer the word written in the previous frame.
// - Bits after the first sixteen repeat input bits in order for chaining.
// - On select rising, latch data only if bit count is a multiple of sixteen.
// - Select high tri-states serial output and resumes fault capture.
// - Five readback address bits pick payload; top two pick the channel.
// - Readback selection persists until a new readback select command.
// - Status reflects select-fall time and since last valid frame; invalid frames ignored.
// - Top returned bit echoes previous watchdog toggle bit.
// - Bits 14 to 10 echo the address bits of the previous valid command.
// - Bit 9 is one in normal mode, else zero.
// - Bits 8 to 0 come from the register the readback address selects.
// - Fault readback: power-on flag then eight fault flags, high to low.
// - Power-on flag set by supply power-on, cleared only by fault readback.
// - Reset, logic supply fail or power-on clear every returned bit but bit 8.
// - Fault pin shows any fault; latched ones stay until a switch-off write.
// - PWM readback: bit 8 zero, bit 7 drive bit, bits 6 to 0 duty.
// - Open-load-lit flag uses bulb or LED threshold as configured per channel.
// - Diag A: clock out of range, calibration failure, temperature prewarning.
// - Diag B: live direct inputs in bits 4 to 1, watchdog enable in bit 0.
module srb_top import srb_pkg::*; #(
	parameter logic [ID_W-1:0] PRODUCT_ID = 3'h5 // Arbitrary value
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_sclk,
	input wire logic i_select_low_pin_n,
	input wire logic i_serial_in,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	input wire logic i_vdd_fail,
	input wire logic i_supply_por,
	input wire logic i_normal_run_flag,
	input wire logic i_low_supply_flag,
	input wire logic i_high_supply_flag,
	input wire srb_chan_fault_type [CH_N-1:0] i_chan_fault,
	input wire srb_diag_type i_diag,
	input wire logic [DIN_N-1:0] i_direct_in,
	output logic o_fault_pin_n,
	output logic [PAY_W-1:0] o_global_cfg
);
	srb_frame_type frame;
	logic link_tog;
	logic [WORD_W-1:0] stat_q;
	logic [DIN_N+1:0] sync_in;
	logic [DIN_N+1:0] sync_out;
	logic cs_high;
	logic tog_s;
	logic [DIN_N-1:0] din_s;
	srb_state_type st_q;
	srb_state_type st_d;
	logic tog_seen_q;
	logic commit_valid;
	logic clear_all;
	logic [ADDR_W-1:0] cmd_addr;
	logic [CODE_W-1:0] cmd_code;
	logic [CH_W-1:0] cmd_ch;
	logic [PAY_W-1:0] cmd_data;
	logic [WORD_W-1:0] prev_q;
	logic [ADDR_W-1:0] sel_q;
	logic [CH_W-1:0] sel_ch;
	logic [PAY_W-1:0] glob_q;
	logic por_q;
	logic fpin_q;
	logic [PAY_W-1:0] pay_d;
	logic [PAY_W-1:0] pwm_q [CH_N];
	logic [PAY_W-1:0] cfga_q [CH_N];
	logic [PAY_W-1:0] cfgb_q [CH_N];
	logic [PAY_W-1:0] ocr_q [CH_N];
	logic [FLT_W-1:0] flt_q [CH_N];
	logic [FLT_W-1:0] live [CH_N];
	logic [CH_N-1:0] lat_q;
	logic [CH_N-1:0] live_any;

	// Serial-clock side; its word input is held still while a frame runs
	srb_link u_link (
		.i_sclk(i_sclk),
		.i_rst_n(i_rst_n),
		.i_select_low_pin_n(i_select_low_pin_n),
		.i_serial_in(i_serial_in),
		.i_tx_word(stat_q),
		.o_serial_out(o_serial_out),
		.o_serial_out_oe(o_serial_out_oe),
		.o_frame(frame),
		.o_frame_tog(link_tog)
	);

	// Select level, frame marker and direct inputs enter this domain
	assign sync_in = {i_select_low_pin_n, link_tog, i_direct_in};
	srb_sync #(
		.W(DIN_N + 2),
		.RST({1'b1, {(DIN_N + 1){1'b0}}})
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_d(sync_in),
		.o_q(sync_out)
	);
	assign cs_high = sync_out[DIN_N+1];
	assign tog_s = sync_out[DIN_N];
	assign din_s = sync_out[DIN_N-1:0];

	// Frame tracking: idle, in frame, one commit cycle after release
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: if (!cs_high) st_d = ST_BUSY;
			ST_BUSY: if (cs_high) st_d = ST_COMMIT;
			ST_COMMIT: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Marker seen at last commit; a frame with no clock edges leaves it unchanged
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tog_seen_q <= 1'b0;
		end else if (st_q == ST_COMMIT) begin
			tog_seen_q <= tog_s;
		end
	end

	// Link words are stable here: the serial clock is idle once select is high
	assign commit_valid = (st_q == ST_COMMIT) && (tog_s != tog_seen_q) && frame.len_ok;
	assign clear_all = i_vdd_fail || i_supply_por;
	assign cmd_addr = frame.word[ADDR_HI:ADDR_LO];
	assign cmd_code = frame.word[CODE_HI:ADDR_LO];
	assign cmd_ch = frame.word[ADDR_HI:CODE_HI+1];
	assign cmd_data = frame.word[PAY_W-1:0];
	assign sel_ch = sel_q[ADDR_W-1:CODE_W];

	// Previous word for echo bits, and the persistent readback selection
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_q <= WORD_ZERO;
			sel_q <= ADDR_SEL;
		end else if (clear_all) begin
			prev_q <= WORD_ZERO;
			sel_q <= ADDR_SEL;
		end else if (commit_valid) begin
			prev_q <= frame.word;
			if (cmd_addr == ADDR_SEL) begin
				sel_q <= frame.word[ADDR_W-1:0];
			end
		end
	end

	// Global configuration
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			glob_q <= PAY_ZERO;
		end else if (clear_all) begin
			glob_q <= PAY_ZERO;
		end else if (commit_valid && cmd_addr == ADDR_GLOB) begin
			glob_q <= cmd_data;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < CH_N; gi++) begin : g_ch
			logic wr_ch;
			logic olon_eff;
			assign wr_ch = commit_valid && (cmd_ch == CH_W'(gi));
			// Open-load-lit threshold follows this channel's configuration
			assign olon_eff = !cfgb_q[gi][OLON_DIS_BIT] &&
				(cfgb_q[gi][OLLED_BIT] ? i_chan_fault[gi].olon_led : i_chan_fault[gi].olon_bulb);
			assign live[gi] = {i_low_supply_flag, i_high_supply_flag, olon_eff, i_chan_fault[gi].oloff,
				i_chan_fault[gi].bat_short, i_chan_fault[gi].overtemp, i_chan_fault[gi].hard_short,
				i_chan_fault[gi].overcurrent};
			assign live_any[gi] = |live[gi];

			// Anything seen outside a frame must survive until the next valid frame
			a_fault_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
				(st_q != ST_BUSY && !clear_all) |=> ($past(live[gi]) & ~flt_q[gi]) == '0)
				else $error("fault seen between frames was dropped");
			a_open_led: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
				(cfgb_q[gi][OLLED_BIT] && !cfgb_q[gi][OLON_DIS_BIT]) |-> olon_eff == i_chan_fault[gi].olon_led)
				else $error("LED open-load threshold not applied");

			// Per-channel configuration written by valid frames only
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					pwm_q[gi] <= PAY_ZERO;
					cfga_q[gi] <= PAY_ZERO;
					cfgb_q[gi] <= PAY_ZERO;
					ocr_q[gi] <= PAY_ZERO;
				end else if (clear_all) begin
					pwm_q[gi] <= PAY_ZERO;
					cfga_q[gi] <= PAY_ZERO;
					cfgb_q[gi] <= PAY_ZERO;
					ocr_q[gi] <= PAY_ZERO;
				end else if (wr_ch) begin
					case (cmd_code)
						CODE_PWM: pwm_q[gi] <= cmd_data;
						CODE_CFGA: cfga_q[gi] <= cmd_data;
						CODE_CFGB: cfgb_q[gi] <= cmd_data;
						CODE_OCR: ocr_q[gi] <= cmd_data;
						default: ;
					endcase
				end
			end

			// Fault capture: frozen in a frame, restarted by a valid frame
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					flt_q[gi] <= '0;
				end else if (clear_all) begin
					flt_q[gi] <= '0;
				end else if (commit_valid) begin
					flt_q[gi] <= live[gi];
				end else if (st_q != ST_BUSY) begin
					flt_q[gi] <= flt_q[gi] | live[gi];
				end
			end

			// Latched protection faults; a switch-off write releases them, new faults win
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					lat_q[gi] <= 1'b0;
				end else if (i_chan_fault[gi].overtemp || i_chan_fault[gi].hard_short ||
					i_chan_fault[gi].overcurrent) begin
					lat_q[gi] <= 1'b1;
				end else if (wr_ch && cmd_code == CODE_PWM && !cmd_data[PWM_ON_BIT]) begin
					lat_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Power-on flag; a new power-on event wins over a clearing readback
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			por_q <= 1'b1;
		end else if (i_supply_por) begin
			por_q <= 1'b1;
		end else if (commit_valid && sel_q[CODE_W-1:0] == CODE_FLT) begin
			por_q <= 1'b0;
		end
	end

	// Fault pin, active low, any live or latched fault
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fpin_q <= 1'b1;
		end else begin
			fpin_q <= !((|live_any) || (|lat_q));
		end
	end

	// Payload multiplexer; unknown addresses read as zero
	always_comb begin
		pay_d = PAY_ZERO;
		case (sel_q)
			ADDR_GLOB: pay_d = glob_q & MASK_GLOB;
			ADDR_DIAGA: pay_d = PAY_W'({i_diag.pwm_clk_bad, i_diag.cal_fail, i_diag.temp_prewarn});
			ADDR_DIAGB: pay_d = PAY_W'({din_s, i_diag.watchdog_active});
			ADDR_DIAGC: pay_d = PAY_W'(PRODUCT_ID);
			default: begin
				case (sel_q[CODE_W-1:0])
					CODE_FLT: pay_d = {por_q, flt_q[sel_ch]};
					CODE_PWM: pay_d = pwm_q[sel_ch] & MASK_PWM;
					CODE_CFGA: pay_d = cfga_q[sel_ch] & MASK_CFGA;
					CODE_CFGB: pay_d = cfgb_q[sel_ch] & MASK_CFGB;
					CODE_OCR: pay_d = ocr_q[sel_ch] & MASK_OCR;
					default: pay_d = PAY_ZERO;
				endcase
			end
		endcase
	end

	// Status word follows state between frames and freezes while one runs
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stat_q <= WORD_ZERO;
		end else if (clear_all) begin
			stat_q <= WORD_ZERO;
		end else if (st_q == ST_IDLE) begin
			stat_q <= {prev_q[WD_BIT], prev_q[ADDR_HI:ADDR_LO], i_normal_run_flag, pay_d};
		end
	end

	assign o_fault_pin_n = fpin_q;
	assign o_global_cfg = glob_q;

	default clocking cb_sys @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	sequence seq_frame_end;
		(st_q == ST_BUSY) ##1 (st_q == ST_COMMIT);
	endsequence

	a_stat_frozen: assert property ((st_q == ST_BUSY && !clear_all) |=> $stable(stat_q))
		else $error("status word moved during a frame");
	a_bad_frame: assert property ((seq_frame_end ##0 (!commit_valid && !clear_all))
		|=> $stable(prev_q) && $stable(sel_q) && $stable(glob_q))
		else $error("invalid frame changed stored state");
	a_good_frame: assert property ((seq_frame_end ##0 (commit_valid && !clear_all))
		|=> prev_q == $past(frame.word))
		else $error("valid frame not latched");
	a_sel_update: assert property ((commit_valid && cmd_addr == ADDR_SEL && !clear_all)
		|=> sel_q == $past(frame.word[ADDR_W-1:0]))
		else $error("readback select not taken");
	a_echo_bits: assert property ((st_q == ST_IDLE && !clear_all)
		|=> stat_q[WORD_W-1:RUN_BIT] == {$past(prev_q[WD_BIT:ADDR_LO]), $past(i_normal_run_flag)})
		else $error("echo or mode bits wrong");
	a_por_set: assert property (i_supply_por |=> por_q ##1 (por_q || commit_valid))
		else $error("power-on flag not set");
	a_por_read: assert property ((commit_valid && sel_q[CODE_W-1:0] == CODE_FLT && !i_supply_por)
		|=> !por_q)
		else $error("power-on flag not cleared by fault readback");
	a_reset_word: assert property (clear_all |=> stat_q == WORD_ZERO && sel_q == ADDR_SEL)
		else $error("status not cleared after supply event");
	a_fault_pin: assert property ((|lat_q) |=> !o_fault_pin_n)
		else $error("fault pin not asserted for latched fault");
	a_fault_pin_live: assert property ((|live_any) |=> !o_fault_pin_n)
		else $error("fault pin not asserted for live fault");
	a_sel_kept: assert property ((st_q != ST_COMMIT && !clear_all) |=> $stable(sel_q))
		else $error("readback selection moved outside a commit");

	// Payload fields, checked one cycle after the status word reloads
	a_fault_por: assert property ((st_q == ST_IDLE && !clear_all && sel_q[CODE_W-1:0] == CODE_FLT)
		|=> stat_q[PAY_W-1] == $past(por_q))
		else $error("power-on bit missing from fault readback");
	a_drive_bit_zero: assert property ((st_q == ST_IDLE && !clear_all && sel_q[CODE_W-1:0] == CODE_PWM)
		|=> !stat_q[PAY_W-1])
		else $error("top payload bit of a drive readback is not zero");
	a_diag_a_flags: assert property ((st_q == ST_IDLE && !clear_all && sel_q == ADDR_DIAGA)
		|=> stat_q[CODE_W-1:0] == {$past(i_diag.pwm_clk_bad), $past(i_diag.cal_fail),
		$past(i_diag.temp_prewarn)})
		else $error("diagnostic A readback wrong");
	a_diag_b_inputs: assert property ((st_q == ST_IDLE && !clear_all && sel_q == ADDR_DIAGB)
		|=> stat_q[DIN_N:0] == {$past(din_s), $past(i_diag.watchdog_active)})
		else $error("direct input readback wrong");
endmodule : srb_top

// >>> rtl/srb_pkg.sv
// Shared constants and carrier types for the SPI status readback block
package srb_pkg;
	localparam int WORD_W = 16;
	localparam int PAY_W = 9;
	localparam int ADDR_W = 5;
	localparam int CODE_W = 3;
	localparam int CH_N = 4;
	localparam int CH_W = 2;
	localparam int CNT_W = 4;
	localparam int DIN_N = 4;
	localparam int FLT_W = 8;
	localparam int ID_W = 3;
	// Field positions inside a 16-bit word
	localparam int WD_BIT = 15;
	localparam int ADDR_HI = 14;
	localparam int ADDR_LO = 10;
	localparam int CODE_HI = 12;
	localparam int RUN_BIT = 9;
	localparam int PWM_ON_BIT = 7;
	localparam int OLLED_BIT = 1;
	localparam int OLON_DIS_BIT = 3;
	localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;
	// Register codes and full addresses
	localparam logic [CODE_W-1:0] CODE_FLT = 3'h0;
	localparam logic [CODE_W-1:0] CODE_PWM = 3'h1;
	localparam logic [CODE_W-1:0] CODE_CFGA = 3'h2;
	localparam logic [CODE_W-1:0] CODE_CFGB = 3'h3;
	localparam logic [CODE_W-1:0] CODE_OCR = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_SEL = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_GLOB = 5'h05;
	localparam logic [ADDR_W-1:0] ADDR_DIAGA = 5'h07;
	localparam logic [ADDR_W-1:0] ADDR_DIAGB = 5'h0F;
	localparam logic [ADDR_W-1:0] ADDR_DIAGC = 5'h17;
	// Readback masks; undefined bits read as zero
	localparam logic [PAY_W-1:0] MASK_PWM = 9'h0FF;
	localparam logic [PAY_W-1:0] MASK_CFGA = 9'h03F;
	localparam logic [PAY_W-1:0] MASK_CFGB = 9'h07F;
	localparam logic [PAY_W-1:0] MASK_OCR = 9'h1FF;
	localparam logic [PAY_W-1:0] MASK_GLOB = 9'h1FD;
	localparam logic [PAY_W-1:0] PAY_ZERO = 9'h000;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

	typedef struct packed {
		logic olon_bulb;
		logic olon_led;
		logic oloff;
		logic bat_short;
		logic overtemp;
		logic hard_short;
		logic overcurrent;
	} srb_chan_fault_type;

	typedef struct packed {
		logic pwm_clk_bad;
		logic cal_fail;
		logic temp_prewarn;
		logic watchdog_active;
	} srb_diag_type;

	typedef struct packed {
		logic len_ok;
		logic [WORD_W-1:0] word;
	} srb_frame_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_BUSY = 3'h2,
		ST_COMMIT = 3'h4
	} srb_state_type;
endpackage : srb_pkg

// >>> rtl/srb_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module srb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_q;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			// Output moves only once stages two and three agree
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1_q[gi] <= RST[gi];
					s2_q[gi] <= RST[gi];
					s3_q[gi] <= RST[gi];
					q_q[gi] <= RST[gi];
				end else begin
					s1_q[gi] <= i_d[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						q_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	assign o_q = q_q;
endmodule : srb_sync

// >>> rtl/srb_link.sv
// Link-side shifter running on the serial clock
`timescale 1ns/1ns
module srb_link import srb_pkg::*; (
	input wire logic i_sclk,
	input wire logic i_rst_n,
	input wire logic i_select_low_pin_n,
	input wire logic i_serial_in,
	input wire logic [WORD_W-1:0] i_tx_word,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	output srb_frame_type o_frame,
	output logic o_frame_tog
);
	logic [CNT_W-1:0] cnt_q;
	logic past_q;
	logic [WORD_W-1:0] rx_q;
	logic len_ok_q;
	logic tog_q;

	// Bit position; the idle select level clears it, so each frame starts at the top
	always_ff @(posedge i_sclk or negedge i_rst_n or posedge i_select_low_pin_n) begin
		if (!i_rst_n || i_select_low_pin_n) begin
			cnt_q <= '0;
			past_q <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			if (cnt_q == CNT_LAST) begin
				past_q <= 1'b1;
			end
		end
	end

	// Received bits, length check and frame marker survive the select release
	always_ff @(posedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_q <= WORD_ZERO;
			len_ok_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			rx_q <= {rx_q[WORD_W-2:0], i_serial_in};
			len_ok_q <= (cnt_q == CNT_LAST);
			if (cnt_q == '0 && !past_q) begin
				tog_q <= ~tog_q;
			end
		end
	end

	// Status word first, then bits received sixteen edges ago
	assign o_serial_out = past_q ? rx_q[WORD_W-1] : i_tx_word[CNT_LAST - cnt_q];
	assign o_serial_out_oe = !i_select_low_pin_n;
	assign o_frame.len_ok = len_ok_q;
	assign o_frame.word = rx_q;
	assign o_frame_tog = tog_q;

	a_pass_through: assert property (@(posedge i_sclk) disable iff (!i_rst_n || i_select_low_pin_n)
		past_q |-> o_serial_out == $past(i_serial_in, 16))
		else $error("chained bit does not match input sixteen edges earlier");
	a_len_check: assert property (@(posedge i_sclk) disable iff (!i_rst_n || i_select_low_pin_n)
		past_q |-> (len_ok_q == (cnt_q == '0)))
		else $error("length flag disagrees with bit count");
	a_first_msb: assert property (@(posedge i_sclk) disable iff (!i_rst_n || i_select_low_pin_n)
		(cnt_q == '0 && !past_q) |-> o_serial_out == i_tx_word[WD_BIT])
		else $error("first bit is not the top status bit");
endmodule : srb_link

// >>> test/srb_host.sv
// Host-side SPI master model for the status readback block
`timescale 1ns/1ns
module srb_host (
	output logic o_sclk,
	output logic o_select_low_pin_n,
	output logic o_serial_in,
	input wire logic i_serial_out,
	input wire logic i_serial_out_oe
);
	// Idle levels; the serial clock stands still outside frames
	initial begin
		o_sclk = 1'b0;
		o_select_low_pin_n = 1'b1;
		o_serial_in = 1'b0;
	end

	// One frame of n bits, top bit first, 64 ns clock; returned bits sampled before each rising edge
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = '0;
		#7 o_select_low_pin_n = 1'b0;
		// Status word may still reload up to five system cycles after select falls
		#550;
		for (int i = n - 1; i >= 0; i--) begin
			o_serial_in = tx[i];
			#32 rx[i] = i_serial_out_oe ? i_serial_out : 1'bx;
			o_sclk = 1'b1;
			#32 o_sclk = 1'b0;
		end
		#32 o_select_low_pin_n = 1'b1;
		// Data line is idle; show the inverse so no stale bit is mistaken for data
		o_serial_in = ~o_serial_in;
		// Long enough high time for commit and status refresh
		#700;
	endtask : xfer
endmodule : srb_host

// >>> test/tb.sv
// Self-checking testbench for the SPI status readback block
`timescale 1ns/1ns
module tb;
	import srb_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic sclk, sel_n, si, so, so_oe, fault_pin_n;
	logic vdd_fail = 1'b0, por = 1'b0, run_flag = 1'b0, low_sup = 1'b0, high_sup = 1'b0;
	srb_chan_fault_type [CH_N-1:0] chf = '0;
	srb_diag_type diag = 4'hB;
	logic [DIN_N-1:0] din = 4'hA;
	logic [PAY_W-1:0] gcfg;
	logic [WORD_W-1:0] prev = '0; // last valid command, echoed next frame
	int bad_count = 0;
	int samples_checked = 0;
	// Command words and the payload each frame should return
	logic [15:0] txs [14] = '{16'hC5C5, 16'h29FF, 16'hEDFF, 16'h11FF, 16'h8011, 16'h000A, 16'h9400,
		16'h001B, 16'h8004, 16'h0007, 16'h800F, 16'h0017, 16'h8001, 16'h0008};
	logic [8:0] pays [14] = '{9'h1A9, 9'h1A9, 9'h1A9, 9'h1A9, 9'h1A9, 9'h0C5, 9'h03F,
		9'h03F, 9'h07F, 9'h1FF, 9'h005, 9'h015, 9'h006, 9'h000};

	// System clock, 100 ns
	always #50 i_clk_sys = ~i_clk_sys;

	srb_host host (.o_sclk(sclk), .o_select_low_pin_n(sel_n), .o_serial_in(si),
		.i_serial_out(so), .i_serial_out_oe(so_oe));

	srb_top #(.PRODUCT_ID(3'h6)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sclk(sclk),
		.i_select_low_pin_n(sel_n), .i_serial_in(si), .o_serial_out(so), .o_serial_out_oe(so_oe),
		.i_vdd_fail(vdd_fail), .i_supply_por(por), .i_normal_run_flag(run_flag), .i_low_supply_flag(low_sup),
		.i_high_supply_flag(high_sup), .i_chan_fault(chf), .i_diag(diag), .i_direct_in(din),
		.o_fault_pin_n(fault_pin_n), .o_global_cfg(gcfg));

	task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_w

	task automatic stop_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	// Sends one 16-bit command; the reply must echo the previous one
	task automatic frame(input logic [15:0] tx, input logic [8:0] pay);
		logic [31:0] rx;
		host.xfer(16, {16'h0000, tx}, rx);
		chk_w("status word", {16'h0000, prev[15:10], run_flag, pay}, rx);
		chk_w("serial output enable", 32'h0, {31'h0, so_oe});
		prev = tx;
	endtask : frame

	task automatic wait_sys(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask : wait_sys

	// First frame after reset: everything zero but the power-on bit
	task automatic t_reset();
		logic [31:0] rx;
		host.xfer(16, 32'h00008005, rx);
		chk_w("word after reset", 32'h0, rx & 32'hFEFF);
		prev = 16'h8005;
	endtask : t_reset

	// Global configuration write, masked readback and port value
	task automatic t_gcr();
		@(negedge i_clk_sys) run_flag = 1'b1;
		frame(16'h15AB, 9'h000);
		frame(16'h8005, 9'h1A9);
		chk_w("global cfg port", 32'h1AB, {23'h0, gcfg});
	endtask : t_gcr

	// Short frame: must change nothing, reply starts with the status word
	task automatic t_bad();
		logic [31:0] rx;
		logic [15:0] st;
		st = {prev[15:10], run_flag, 9'h1FF};
		host.xfer(12, 32'h00000017, rx);
		chk_w("short frame", {20'h0, st[15:4]}, rx);
	endtask : t_bad

	// Fault readback, open-load threshold, stickiness and latched fault pin
	task automatic t_fault();
		@(negedge i_clk_sys) begin
			low_sup = 1'b1;
			high_sup = 1'b1;
			chf[1].overcurrent = 1'b1;
			chf[1].olon_led = 1'b1;
		end
		wait_sys(3);
		chk_w("fault pin", 32'h0, {31'h0, fault_pin_n});
		frame(16'hAC02, 9'h0C1);
		@(negedge i_clk_sys) begin
			low_sup = 1'b0;
			high_sup = 1'b0;
			chf[1].overcurrent = 1'b0;
		end
		frame(16'h0008, 9'h0E1);
		@(negedge i_clk_sys) chf[1].olon_led = 1'b0;
		wait_sys(5);
		chk_w("fault pin latched", 32'h0, {31'h0, fault_pin_n});
		frame(16'hA405, 9'h020);
		wait_sys(5);
		chk_w("fault pin released", 32'h1, {31'h0, fault_pin_n});
	endtask : t_fault

	// Supply events clear the word; power-on flag set, cleared by a fault read
	task automatic t_supply();
		logic [31:0] rx;
		@(negedge i_clk_sys) begin
			run_flag = 1'b0;
			vdd_fail = 1'b1;
		end
		@(negedge i_clk_sys) vdd_fail = 1'b0;
		wait_sys(6);
		host.xfer(16, 32'h0, rx);
		chk_w("word after supply fail", 32'h0, rx & 32'hFEFF);
		@(negedge i_clk_sys) por = 1'b1;
		@(negedge i_clk_sys) por = 1'b0;
		wait_sys(6);
		prev = 16'h0000;
		frame(16'h0000, 9'h100);
		frame(16'h0000, 9'h000);
	endtask : t_supply

	// Double-length frame: second half passes the input through
	task automatic t_chain();
		logic [31:0] rx;
		host.xfer(32, 32'hA5C30000, rx);
		chk_w("chained frame", {16'h0000, 16'hA5C3}, rx);
		prev = 16'h0000;
	endtask : t_chain

	// Main sequence
	initial begin
		wait_sys(5);
		i_rst_n = 1'b1;
		wait_sys(6);
		t_reset();
		t_gcr();
		for (int i = 0; i < 14; i++) begin
			frame(txs[i], pays[i]);
			if (i == 8) begin
				t_bad();
			end
		end
		t_fault();
		t_supply();
		t_chain();
		stop_test();
	end

	// Watchdog, several times the expected run length
	initial begin
		#500000;
		bad_count++;
		stop_test();
	end
endmodule : tb
